// [rtl/pbar_regs.sv]
// Power budgeting and access control configuration register bank.
// Assumes a synchronous register port, strobes one cycle long, and
// a loader that presents preset values with a one-cycle load pulse.
// Register map, byte offsets on the 12-bit address
//   20Ch  Budget header: next pointer, version, identifier; all read-only
//   210h  Budget selector: bits 7:0 writable, the rest read zero
//   214h  Budget data: rail, type, state, sub state, scale, base power
//   218h  System allocated flag in bit 0, loaded from the preset store
//   220h  Access control header, downstream ports only
//   224h  Access control capabilities, vector size and feature enables
//   228h  Egress block vector, eight writable bits
//
// Default budget data word reads 000B_8004h: rail 010b, type 111b,
// state and sub state zero, scale zero, base power 04h.
//
// Hazards and limits
//   Both supported selector values report one stored figure set, so a
//   preset load changes the maximum and the sustained budget together.
//   On the upstream port the access control registers read zero and the
//   enables and egress vector toward the forwarding logic are held off.
//   The strap input is expected to stay static; a change takes effect at
//   once on the read views and on the outputs.
`timescale 1ns/1ns

module pbar_regs
	import pbar_pkg::*;
(
	input  wire logic        ref_clk_i,      // Core clock, 100 MHz
	input  wire logic        rst_i,          // Synchronous reset, active high
	input  wire logic        is_upstream_i,  // High when this port faces upstream
	input  wire logic [11:0] addr_i,         // Register byte address
	input  wire logic [31:0] wdata_i,        // Write data
	input  wire logic        wr_i,           // Write strobe
	input  wire logic        rd_i,           // Read strobe
	output logic      [31:0] rdata_o,        // Read data, cycle after read strobe
	input  wire logic        load_i,         // Preset load pulse
	input  wire logic [7:0]  load_base_pwr_i,// Preset base power in watts
	input  wire logic        load_alloc_i,   // Preset system allocated flag
	output logic      [6:0]  acs_enables_o,  // Feature enables to forwarding logic
	output logic      [7:0]  egress_block_o  // Egress block vector
);

	// ==========================================================
	// Storage
	logic [7:0]  sel_q;
	logic [7:0]  sel_d;
	logic [7:0]  base_pwr_q;
	logic [7:0]  base_pwr_d;
	logic        alloc_q;
	logic        alloc_d;
	logic [6:0]  acs_en_q;
	logic [6:0]  acs_en_d;
	logic [7:0]  egr_q;
	logic [7:0]  egr_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// ==========================================================
	// Address decode
	wire logic hit_pb_hdr   = (addr_i == PBAR_OFF_PB_HDR);
	wire logic hit_pb_sel   = (addr_i == PBAR_OFF_PB_SEL);
	wire logic hit_pb_data  = (addr_i == PBAR_OFF_PB_DATA);
	wire logic hit_pb_alloc = (addr_i == PBAR_OFF_PB_ALLOC);
	// Access control registers vanish on the upstream port
	wire logic acs_present  = !is_upstream_i;
	wire logic hit_acs_hdr  = acs_present && (addr_i == PBAR_OFF_ACS_HDR);
	wire logic hit_acs_ctl  = acs_present && (addr_i == PBAR_OFF_ACS_CTL);
	wire logic hit_acs_egr  = acs_present && (addr_i == PBAR_OFF_ACS_EGR);

	// ==========================================================
	// Read views of each register
	wire logic [11:0] pb_next = is_upstream_i ? PBAR_PB_NEXT_UP : PBAR_PB_NEXT_DN;
	wire logic [31:0] pb_hdr_word = {pb_next, PBAR_CAP_VER, PBAR_PB_CAP_ID};
	wire logic [31:0] acs_hdr_word = {PBAR_ACS_NEXT, PBAR_CAP_VER, PBAR_ACS_CAP_ID};

	// Both supported entries share the same stored figures
	wire logic sel_valid = (sel_q == PBAR_SEL_D0_MAX) || (sel_q == PBAR_SEL_D0_SUST);
	pbar_budget_s budget;
	assign budget.rsvd      = '0;
	assign budget.rail      = PBAR_RAIL_RST;
	assign budget.cond_type = PBAR_TYPE_RST;
	assign budget.pm_state  = PBAR_PMST_RST;
	assign budget.sub_state = PBAR_SUBST_RST;
	assign budget.scale     = PBAR_SCALE_RST;
	assign budget.base_pwr  = base_pwr_q;
	wire logic [31:0] data_word = sel_valid ? budget : 32'h0000_0000;

	pbar_acs_ctl_s acs_ctl;
	assign acs_ctl.rsvd_hi  = '0;
	assign acs_ctl.enables  = acs_en_q;
	assign acs_ctl.egr_size = PBAR_EGR_SIZE;
	assign acs_ctl.rsvd_lo  = 1'b0;
	assign acs_ctl.caps     = PBAR_ACS_CAPS;

	// Read mux, unmapped addresses read zero
	always_comb begin
		if (!rd_i) begin
			rdata_d = rdata_q;
		end else if (hit_pb_hdr) begin
			rdata_d = pb_hdr_word;
		end else if (hit_pb_sel) begin
			rdata_d = {24'h00_0000, sel_q};
		end else if (hit_pb_data) begin
			rdata_d = data_word;
		end else if (hit_pb_alloc) begin
			rdata_d = {31'h0000_0000, alloc_q};
		end else if (hit_acs_hdr) begin
			rdata_d = acs_hdr_word;
		end else if (hit_acs_ctl) begin
			rdata_d = acs_ctl;
		end else if (hit_acs_egr) begin
			rdata_d = {24'h00_0000, egr_q};
		end else begin
			rdata_d = 32'h0000_0000;
		end
	end

	// ==========================================================
	// Next values: only writable fields take write data
	assign sel_d      = (wr_i && hit_pb_sel) ? wdata_i[7:0] : sel_q;
	assign acs_en_d   = (wr_i && hit_acs_ctl)
		? wdata_i[PBAR_ACS_EN_LSB +: 7] : acs_en_q;
	assign egr_d      = (wr_i && hit_acs_egr) ? wdata_i[7:0] : egr_q;
	// Read-only figures change only from the preset loader
	assign base_pwr_d = load_i ? load_base_pwr_i : base_pwr_q;
	assign alloc_d    = load_i ? load_alloc_i : alloc_q;

	// Register update
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sel_q      <= PBAR_SEL_RST;
			base_pwr_q <= PBAR_BASE_PWR_RST;
			alloc_q    <= 1'b0;
			acs_en_q   <= PBAR_ACS_EN_RST;
			egr_q      <= PBAR_EGR_RST;
			rdata_q    <= 32'h0000_0000;
		end else begin
			sel_q      <= sel_d;
			base_pwr_q <= base_pwr_d;
			alloc_q    <= alloc_d;
			acs_en_q   <= acs_en_d;
			egr_q      <= egr_d;
			rdata_q    <= rdata_d;
		end
	end

	// ==========================================================
	// Outputs; controls held off on the upstream port
	assign rdata_o        = rdata_q;
	assign acs_enables_o  = acs_present ? acs_en_q : PBAR_ACS_EN_RST;
	assign egress_block_o = acs_present ? egr_q : PBAR_EGR_RST;

endmodule

// [common/pbar_pkg.sv]
// Package for the power budgeting and access control register bank.
// Assumes a plain register port with 12-bit byte addresses and 32-bit data.
package pbar_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] PBAR_OFF_PB_HDR    = 12'h20c;
	localparam logic [11:0] PBAR_OFF_PB_SEL    = 12'h210;
	localparam logic [11:0] PBAR_OFF_PB_DATA   = 12'h214;
	localparam logic [11:0] PBAR_OFF_PB_ALLOC  = 12'h218;
	localparam logic [11:0] PBAR_OFF_ACS_HDR   = 12'h220;
	localparam logic [11:0] PBAR_OFF_ACS_CTL   = 12'h224;
	localparam logic [11:0] PBAR_OFF_ACS_EGR   = 12'h228;

	// ==========================================================
	// Capability header fields
	localparam logic [15:0] PBAR_PB_CAP_ID     = 16'h0004;
	localparam logic [15:0] PBAR_ACS_CAP_ID    = 16'h000d;
	localparam logic [3:0]  PBAR_CAP_VER       = 4'h1;
	localparam logic [11:0] PBAR_PB_NEXT_UP    = 12'h230;
	localparam logic [11:0] PBAR_PB_NEXT_DN    = 12'h220;
	localparam logic [11:0] PBAR_ACS_NEXT      = 12'h240;

	// ==========================================================
	// Budget selector values and data field defaults
	localparam logic [7:0]  PBAR_SEL_D0_MAX    = 8'h00;
	localparam logic [7:0]  PBAR_SEL_D0_SUST   = 8'h01;
	localparam logic [7:0]  PBAR_SEL_RST       = 8'h00;
	localparam logic [7:0]  PBAR_BASE_PWR_RST  = 8'h04;
	localparam logic [1:0]  PBAR_SCALE_RST     = 2'h0;
	localparam logic [2:0]  PBAR_SUBST_RST     = 3'h0;
	localparam logic [1:0]  PBAR_PMST_RST      = 2'h0;
	localparam logic [2:0]  PBAR_TYPE_RST      = 3'h7;
	localparam logic [2:0]  PBAR_RAIL_RST      = 3'h2;

	// ==========================================================
	// Access control fields
	localparam logic [6:0]  PBAR_ACS_CAPS      = 7'h7f;
	localparam logic [7:0]  PBAR_EGR_SIZE      = 8'h08;
	localparam logic [6:0]  PBAR_ACS_EN_RST    = 7'h00;
	localparam logic [7:0]  PBAR_EGR_RST       = 8'h00;
	localparam int          PBAR_ACS_EN_LSB    = 16;

	// Budget data word as it sits in the register, low field last
	typedef struct packed {
		logic [10:0] rsvd;
		logic [2:0]  rail;
		logic [2:0]  cond_type;
		logic [1:0]  pm_state;
		logic [2:0]  sub_state;
		logic [1:0]  scale;
		logic [7:0]  base_pwr;
	} pbar_budget_s;

	// Access control capability and control word
	typedef struct packed {
		logic [8:0]  rsvd_hi;
		logic [6:0]  enables;
		logic [7:0]  egr_size;
		logic        rsvd_lo;
		logic [6:0]  caps;
	} pbar_acs_ctl_s;

endpackage

// [verif/pbar_regs_assertions.sv]
// Checker for the register bank, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module pbar_regs_assertions (
	input wire logic        ref_clk_i,       // Clock
	input wire logic        rst_i,           // Reset
	input wire logic        is_upstream_i,   // Strap
	input wire logic [11:0] addr_i,          // Address
	input wire logic [31:0] wdata_i,         // Write data
	input wire logic        wr_i,            // Write strobe
	input wire logic        rd_i,            // Read strobe
	input wire logic [31:0] rdata_o,         // Read data
	input wire logic        load_i,          // Preset pulse
	input wire logic [7:0]  load_base_pwr_i, // Preset power
	input wire logic        load_alloc_i,    // Preset flag
	input wire logic [6:0]  acs_enables_o,   // Enables
	input wire logic [7:0]  egress_block_o   // Egress vector
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// Read answers one cycle after the strobe
	wire rd_dn = rd_i & ~is_upstream_i;
	wire rd_up = rd_i & is_upstream_i;
	a_pb_hdr_dn: assert property (
		rd_dn && addr_i == 12'h20c |=> rdata_o == 32'h2201_0004) else $error("pb hdr dn");
	a_pb_hdr_up: assert property (
		rd_up && addr_i == 12'h20c |=> rdata_o == 32'h2301_0004) else $error("pb hdr up");
	a_acs_hdr_dn: assert property (
		rd_dn && addr_i == 12'h220 |=> rdata_o == 32'h2401_000d) else $error("acs hdr");
	a_acs_hidden_up: assert property (
		rd_up && addr_i[11:4] == 8'h22 |=> rdata_o == 32'h0000_0000) else $error("acs up");
	a_data_fields: assert property (
		rd_i && addr_i == 12'h214 |=> rdata_o[31:21] == 11'h000
		&& (rdata_o[20:0] == 21'h0 || rdata_o[20:8] == 13'h0b80)) else $error("data");
	a_ctl_fixed: assert property (
		rd_dn && addr_i == 12'h224 |=> rdata_o[15:0] == 16'h087f
		&& rdata_o[31:23] == 9'h000) else $error("ctl ro");
	a_en_mirror: assert property (
		rd_dn && addr_i == 12'h224 |=> rdata_o[22:16] == $past(acs_enables_o)) else $error("en");
	a_egr_write: assert property (
		wr_i && !is_upstream_i && addr_i == 12'h228
		|=> {24'h0, egress_block_o} == ($past(wdata_i) & 32'h0000_00ff)) else $error("egr");
	a_up_quiet: assert property (
		is_upstream_i |-> acs_enables_o == 7'h00 && egress_block_o == 8'h00) else $error("up");
	c_ctl_read: cover property (rd_dn && addr_i == 12'h224);
	c_preset: cover property (load_i && load_alloc_i);
	c_egr_wr: cover property (wr_i && addr_i == 12'h228 && !is_upstream_i);
endmodule
bind pbar_regs pbar_regs_assertions pbar_regs_assertions_i (.ref_clk_i(ref_clk_i),
	.rst_i(rst_i), .is_upstream_i(is_upstream_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .load_i(load_i),
	.load_base_pwr_i(load_base_pwr_i), .load_alloc_i(load_alloc_i),
	.acs_enables_o(acs_enables_o), .egress_block_o(egress_block_o));

// [verif/testbench.sv]
// Self-checking bench for the register bank.
// Assumes the checker is bound to the design.
`timescale 1ns/1ns
module testbench;
	logic        clk = 0, rst = 1, up = 0, wr = 0, rd = 0, ld = 0, ld_al = 0;
	logic [11:0] addr = 0;
	logic [31:0] wd = 0;
	logic [7:0]  ld_pw = 0;
	wire  [31:0] rdata;
	wire  [6:0]  en;
	wire  [7:0]  egr;
	int          n_errors = 0, check_count = 0, cyc = 0;
	pbar_regs pbar_regs_i (.ref_clk_i(clk), .rst_i(rst), .is_upstream_i(up), .addr_i(addr),
		.wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .load_i(ld),
		.load_base_pwr_i(ld_pw), .load_alloc_i(ld_al), .acs_enables_o(en), .egress_block_o(egr));
	// ==========================================================
	// Clock and hang guard
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr32(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk) begin wr <= 1; addr <= a; wd <= d; end
		@(posedge clk) wr <= 0;
	endtask
	task automatic rd32(input string nm, input logic [11:0] a, input logic [31:0] e);
		@(posedge clk) begin rd <= 1; addr <= a; end
		@(posedge clk) rd <= 0;
		#1 chk(nm, e, rdata);
	endtask
	task automatic do_reset(input logic u);
		@(posedge clk) begin rst <= 1; up <= u; end
		repeat (12) @(posedge clk);
		rst <= 0;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_defaults();
		rd32("pb_hdr", 12'h20c, 32'h2201_0004);
		rd32("sel", 12'h210, 32'h0000_0000);
		rd32("data", 12'h214, 32'h000b_8004);
		rd32("alloc", 12'h218, 32'h0000_0000);
		rd32("acs_hdr", 12'h220, 32'h2401_000d);
		rd32("acs_ctl", 12'h224, 32'h0000_087f);
		rd32("egr", 12'h228, 32'h0000_0000);
		rd32("unmapped", 12'h230, 32'h0000_0000);
		$display("defaults done");
	endtask
	task automatic t_select();
		wr32(12'h210, 32'hffff_ff01);
		rd32("sel", 12'h210, 32'h0000_0001);
		rd32("data_sust", 12'h214, 32'h000b_8004);
		wr32(12'h210, 32'h0000_0002);
		rd32("data_2", 12'h214, 32'h0000_0000);
		wr32(12'h210, 32'h0000_00ff);
		rd32("data_ff", 12'h214, 32'h0000_0000);
		wr32(12'h210, 32'h0000_0000);
		rd32("data_max", 12'h214, 32'h000b_8004);
		$display("select done");
	endtask
	task automatic t_acs();
		wr32(12'h224, 32'hffff_ffff);
		rd32("ctl_all", 12'h224, 32'h007f_087f);
		chk("en_o", 32'h0000_007f, {25'h0, en});
		wr32(12'h224, 32'h0015_0000);
		#1;
		chk("en_o", 32'h0000_0015, {25'h0, en});
		wr32(12'h228, 32'hffff_ffa5);
		rd32("egr", 12'h228, 32'h0000_00a5);
		chk("egr_o", 32'h0000_00a5, {24'h0, egr});
		wr32(12'h20c, 32'hffff_ffff);
		wr32(12'h214, 32'hffff_ffff);
		rd32("hdr_ro", 12'h20c, 32'h2201_0004);
		rd32("data_ro", 12'h214, 32'h000b_8004);
		$display("acs done");
	endtask
	task automatic t_load();
		@(posedge clk) begin ld <= 1; ld_pw <= 8'h2a; ld_al <= 1; end
		@(posedge clk) ld <= 0;
		rd32("data_ld", 12'h214, 32'h000b_802a);
		rd32("alloc_ld", 12'h218, 32'h0000_0001);
		$display("load done");
	endtask
	task automatic t_upstream();
		do_reset(1);
		rd32("pb_hdr_up", 12'h20c, 32'h2301_0004);
		rd32("acs_hdr_up", 12'h220, 32'h0000_0000);
		wr32(12'h228, 32'h0000_00ff);
		rd32("egr_up", 12'h228, 32'h0000_0000);
		chk("egr_o_up", 32'h0000_0000, {24'h0, egr});
		rd32("data_up", 12'h214, 32'h000b_8004);
		$display("upstream done");
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		do_reset(0);
		t_defaults();
		t_select();
		t_acs();
		t_load();
		t_upstream();
		final_report();
	end
endmodule
